// >>> inc/npi_params.svh
// Constants for the nested priority interrupt controller
`ifndef NPI_PARAMS_SVH
`define NPI_PARAMS_SVH

// Register offsets on the plain register port
`define NPI_OFF_PRIO0 8'h24
`define NPI_OFF_PRIO1 8'h25
`define NPI_OFF_PRIO2 8'h26
`define NPI_OFF_PRIO3 8'h27
`define NPI_OFF_FLAGS 8'h20
`define NPI_OFF_STATUS 8'h21

// Reset values
`define NPI_FLAGS_RESET 8'hea
`define NPI_PRIO_RESET 8'hff
`define NPI_PRIO3_RO_ONES 8'hf0

// Flag bit positions
`define NPI_LVL_HI_POS 5
`define NPI_LVL_LO_POS 3
`define NPI_FIXED_ONES 8'hc0
`define NPI_ARITH_MASK 8'h17

// Level encodings {level_high_bit, level_low_bit}
`define NPI_LVL0 2'b10
`define NPI_LVL3 2'b11

// Vector sets, one bit per maskable vector
`define NPI_USED_MASK 14'h3fbe
`define NPI_HALT_MASK 14'h20be
`define NPI_AHALT_MASK 14'h0002

// Vector addresses
`define NPI_VEC_RESET 16'hfffe
`define NPI_VEC_TRAP 16'hfffc
`define NPI_VEC_BASE 16'hfffa

// Index of the last of the four registers stacked on entry
`define NPI_PUSH_LAST 2'd3

`endif

// >>> inc/npi_pkg.sv
// Types for the nested priority interrupt controller
package npi_pkg;

  typedef enum logic [1:0] {
    NPI_ST_RESET = 2'b00,
    NPI_ST_IDLE = 2'b01,
    NPI_ST_PUSH = 2'b10,
    NPI_ST_LOAD = 2'b11
  } npi_state_type;

  typedef struct packed {
    npi_state_type state;
    logic [1:0] cnt;
    logic is_trap;
    logic [3:0] vec_id;
    logic [7:0] flags;
    logic [3:0][7:0] prio;
    logic [7:0] rdata;
    logic [15:0] vec_addr;
    logic vec_load;
    logic push_stb;
    logic [1:0] push_sel;
    logic ack;
    logic [3:0] last_vec;
  } npi_regs_type;

endpackage

// >>> core/npi_ctrl.sv
// Nested priority interrupt controller: level bits, priority registers, vector entry
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "npi_params.svh"

module npi_ctrl
  import npi_pkg::*;
#(
  parameter int NUM_VEC = 14
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Request sources, already gated by their enables
  input wire logic [13:0] irq_req,
  // CPU core instruction events
  input wire logic cpu_boundary,
  input wire logic enable_interrupts_instr,
  input wire logic disable_interrupts_instr,
  input wire logic halt_instr,
  input wire logic wait_for_request_instr,
  input wire logic trap_instr,
  input wire logic flags_restore,
  input wire logic [7:0] flags_restore_data,
  input wire logic arith_flags_wr,
  input wire logic [7:0] arith_flags_data,
  // Power mode status
  input wire logic halt_mode,
  input wire logic active_halt_mode,
  // Service sequence to the CPU core
  output logic push_strobe,
  output logic [1:0] push_sel,
  output logic vector_load,
  output logic [15:0] vector_addr,
  output logic service_ack,
  output logic [3:0] service_vector,
  output logic entry_busy,
  // Flags and conditions
  output logic [7:0] cpu_flags_with_level_bits,
  output logic jump_if_masked,
  output logic jump_if_unmasked,
  output logic wake_req
);

  if (NUM_VEC < 1 || NUM_VEC > 14) begin : g_check
    $error("NUM_VEC must lie between 1 and 14");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Higher result means higher software level
  function automatic logic [1:0] lvl_rank(input logic [1:0] p);
    case (p)
      2'b10: lvl_rank = 2'd0;
      2'b01: lvl_rank = 2'd1;
      2'b00: lvl_rank = 2'd2;
      default: lvl_rank = 2'd3;
    endcase
  endfunction

  function automatic logic [1:0] pair_of(input logic [3:0][7:0] pr, input logic [3:0] v);
    pair_of = pr[v[3:2]][{v[1:0], 1'b0} +: 2];
  endfunction

  function automatic logic [1:0] lvl_of(input logic [7:0] f);
    lvl_of = {f[`NPI_LVL_HI_POS], f[`NPI_LVL_LO_POS]};
  endfunction

  function automatic logic [7:0] set_lvl(input logic [7:0] f, input logic [1:0] l);
    logic [7:0] r;
    r = f;
    r[`NPI_LVL_HI_POS] = l[1];
    r[`NPI_LVL_LO_POS] = l[0];
    set_lvl = r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  npi_regs_type s_q;
  npi_regs_type s_d;
  logic [13:0] cand;
  logic sel_valid;
  logic [3:0] sel_vec;
  logic [1:0] sel_rank;
  logic [1:0] cur_rank;
  logic go;
  logic [1:0] load_pair;
  logic [1:0] wsel;

  ////////////////////////////////////////////////////////////////////////////
  // Request selection

  assign cur_rank = lvl_rank(lvl_of(s_q.flags));
  assign load_pair = pair_of(s_q.prio, s_q.vec_id);

  always_comb begin
    cand = irq_req & `NPI_USED_MASK;
    // Out of halt only wake-capable vectors may be taken first
    if (active_halt_mode) begin
      cand = cand & `NPI_AHALT_MASK;
    end else if (halt_mode) begin
      cand = cand & `NPI_HALT_MASK;
    end
    sel_valid = 1'b0;
    sel_vec = 4'h0;
    sel_rank = 2'd0;
    // Ascending scan with strict compare keeps the lower vector on a tie
    for (int i = 0; i < NUM_VEC; i++) begin
      if (cand[i] && lvl_rank(pair_of(s_q.prio, 4'(i))) > cur_rank) begin
        if (!sel_valid || lvl_rank(pair_of(s_q.prio, 4'(i))) > sel_rank) begin
          sel_valid = 1'b1;
          sel_vec = 4'(i);
          sel_rank = lvl_rank(pair_of(s_q.prio, 4'(i)));
        end
      end
    end
  end

  // Trap bypasses the level check entirely
  assign go = cpu_boundary && (s_q.state == NPI_ST_IDLE) && (trap_instr || sel_valid);

  assign wake_req = (halt_mode && |(irq_req & `NPI_HALT_MASK))
                 || (active_halt_mode && |(irq_req & `NPI_AHALT_MASK));

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  assign wsel = reg_addr[1:0];

  always_comb begin
    s_d = s_q;
    s_d.vec_load = 1'b0;
    s_d.push_stb = 1'b0;
    s_d.ack = 1'b0;
    s_d.rdata = 8'h00;

    // Arithmetic flag updates never touch the level bits
    if (arith_flags_wr) begin
      s_d.flags = (s_q.flags & ~`NPI_ARITH_MASK) | (arith_flags_data & `NPI_ARITH_MASK);
    end

    case (s_q.state)
      NPI_ST_RESET: begin
        s_d.flags = `NPI_FLAGS_RESET;
        s_d.vec_addr = `NPI_VEC_RESET;
        s_d.vec_load = 1'b1;
        s_d.state = NPI_ST_IDLE;
      end
      NPI_ST_IDLE: begin
        if (go) begin
          s_d.is_trap = trap_instr;
          s_d.vec_id = trap_instr ? 4'h0 : sel_vec;
          s_d.cnt = 2'd0;
          s_d.push_stb = 1'b1;
          s_d.push_sel = 2'd0;
          s_d.state = NPI_ST_PUSH;
        end else if (flags_restore) begin
          s_d.flags = flags_restore_data | `NPI_FIXED_ONES;
        end else if (disable_interrupts_instr) begin
          s_d.flags = set_lvl(s_d.flags, `NPI_LVL3);
        end else if (enable_interrupts_instr || halt_instr || wait_for_request_instr) begin
          s_d.flags = set_lvl(s_d.flags, `NPI_LVL0);
        end
      end
      NPI_ST_PUSH: begin
        // Order PC, X, A, flags; the flags pushed still hold the old level
        if (s_q.cnt == `NPI_PUSH_LAST) begin
          s_d.state = NPI_ST_LOAD;
        end else begin
          s_d.cnt = s_q.cnt + 2'd1;
          s_d.push_stb = 1'b1;
          s_d.push_sel = s_q.cnt + 2'd1;
        end
      end
      NPI_ST_LOAD: begin
        s_d.vec_load = 1'b1;
        if (s_q.is_trap) begin
          s_d.flags = set_lvl(s_d.flags, `NPI_LVL3);
          s_d.vec_addr = `NPI_VEC_TRAP;
        end else begin
          s_d.flags = set_lvl(s_d.flags, load_pair);
          s_d.vec_addr = `NPI_VEC_BASE - {11'h000, s_q.vec_id, 1'b0};
          s_d.ack = 1'b1;
          s_d.last_vec = s_q.vec_id;
        end
        s_d.state = NPI_ST_IDLE;
      end
      default: begin
        s_d.state = NPI_ST_IDLE;
      end
    endcase

    // Register writes, pair by pair
    if (reg_wr && reg_addr[7:2] == 6'(`NPI_OFF_PRIO0 >> 2)) begin
      for (int p = 0; p < 4; p++) begin
        if (reg_wdata[2*p +: 2] != `NPI_LVL0) begin
          s_d.prio[wsel][2*p +: 2] = reg_wdata[2*p +: 2];
        end
      end
      s_d.prio[3] = s_d.prio[3] | `NPI_PRIO3_RO_ONES;
    end

    // Register reads, answered in the next cycle
    if (reg_rd) begin
      case (reg_addr)
        `NPI_OFF_PRIO0: s_d.rdata = s_q.prio[0];
        `NPI_OFF_PRIO1: s_d.rdata = s_q.prio[1];
        `NPI_OFF_PRIO2: s_d.rdata = s_q.prio[2];
        `NPI_OFF_PRIO3: s_d.rdata = s_q.prio[3] | `NPI_PRIO3_RO_ONES;
        `NPI_OFF_FLAGS: s_d.rdata = s_q.flags;
        `NPI_OFF_STATUS: s_d.rdata = {s_q.state != NPI_ST_IDLE, 3'h0, s_q.last_vec};
        default: s_d.rdata = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      s_q <= '0;
      s_q.state <= NPI_ST_RESET;
      s_q.flags <= `NPI_FLAGS_RESET;
      s_q.prio <= {4{`NPI_PRIO_RESET}};
      s_q.vec_addr <= `NPI_VEC_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign reg_rdata = s_q.rdata;
  assign push_strobe = s_q.push_stb;
  assign push_sel = s_q.push_sel;
  assign vector_load = s_q.vec_load;
  assign vector_addr = s_q.vec_addr;
  assign service_ack = s_q.ack;
  assign service_vector = s_q.last_vec;
  assign entry_busy = (s_q.state != NPI_ST_IDLE);
  assign cpu_flags_with_level_bits = s_q.flags;
  assign jump_if_masked = (lvl_of(s_q.flags) == `NPI_LVL3);
  assign jump_if_unmasked = !jump_if_masked;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence push_run_s;
    push_strobe [*4];
  endsequence

  sequence load_step_s;
    !push_strobe && vector_load;
  endsequence

  // Load state cycle between the last push and the vector load
  sequence gap_step_s;
    !push_strobe && !vector_load && entry_busy;
  endsequence

  reset_vector_a: assert property ($rose(reset_n) |=> vector_load &&
      vector_addr == `NPI_VEC_RESET && cpu_flags_with_level_bits == `NPI_FLAGS_RESET)
    else $error("reset vector not fetched with reset flags");

  entry_seq_a: assert property (go |=> push_run_s ##1 gap_step_s ##1 load_step_s)
    else $error("entry did not push four registers then load vector");

  push_order_a: assert property ($rose(push_strobe) |-> push_sel == 2'd0
      ##1 push_sel == 2'd1 ##1 push_sel == 2'd2 ##1 push_sel == 2'd3)
    else $error("push order wrong");

  level_load_a: assert property (s_q.state == NPI_ST_LOAD && !s_q.is_trap
      |=> lvl_of(cpu_flags_with_level_bits) == $past(load_pair) && service_ack)
    else $error("level not loaded from vector priority");

  trap_level_a: assert property (s_q.state == NPI_ST_LOAD && s_q.is_trap
      |=> jump_if_masked && vector_addr == `NPI_VEC_TRAP)
    else $error("trap entry did not mask");

  level_gate_a: assert property (go && !trap_instr |-> sel_rank > cur_rank)
    else $error("request taken at or below current level");

  enable_instr_a: assert property (s_q.state == NPI_ST_IDLE && !go &&
      enable_interrupts_instr && !flags_restore && !disable_interrupts_instr
      |=> lvl_of(cpu_flags_with_level_bits) == `NPI_LVL0)
    else $error("enable did not load level 0");

  level0_keep_a: assert property (reg_wr && reg_addr == `NPI_OFF_PRIO0 &&
      reg_wdata[1:0] == `NPI_LVL0 |=> s_q.prio[0][1:0] == $past(s_q.prio[0][1:0]))
    else $error("level 0 written into priority pair");

  prio3_top_a: assert property (reg_rd && reg_addr == `NPI_OFF_PRIO3
      |=> reg_rdata[7:4] == 4'hf)
    else $error("upper nibble of priority register 3 not ones");

  mask_jump_a: assert property (jump_if_masked ==
      (cpu_flags_with_level_bits[`NPI_LVL_HI_POS] && cpu_flags_with_level_bits[`NPI_LVL_LO_POS]))
    else $error("masked jump condition wrong");

  disable_instr_a: assert property (s_q.state == NPI_ST_IDLE && !go &&
      disable_interrupts_instr && !flags_restore |=> jump_if_masked)
    else $error("disable did not load level 3");

  restore_instr_a: assert property (s_q.state == NPI_ST_IDLE && !go && flags_restore
      |=> cpu_flags_with_level_bits == ($past(flags_restore_data) | `NPI_FIXED_ONES))
    else $error("flags not restored from stack");

  wait_instr_a: assert property (s_q.state == NPI_ST_IDLE && !go && !flags_restore &&
      !disable_interrupts_instr && (halt_instr || wait_for_request_instr)
      |=> lvl_of(cpu_flags_with_level_bits) == `NPI_LVL0)
    else $error("halt or wait did not load level 0");

  trap_take_a: assert property (cpu_boundary && trap_instr && s_q.state == NPI_ST_IDLE
      |=> push_strobe && push_sel == 2'd0)
    else $error("trap not taken at current level");

  unused_vec_a: assert property (go && !trap_instr
      |-> sel_vec != 4'h0 && sel_vec != 4'h6)
    else $error("unused vector selected");

  halt_filter_a: assert property (go && !trap_instr && halt_mode
      |-> |((14'h0001 << sel_vec) & `NPI_HALT_MASK))
    else $error("vector without halt exit taken in halt");

  ahalt_filter_a: assert property (go && !trap_instr && active_halt_mode
      |-> |((14'h0001 << sel_vec) & `NPI_AHALT_MASK))
    else $error("vector without active halt exit taken");

  ack_addr_a: assert property (service_ack |-> vector_load &&
      vector_addr == `NPI_VEC_BASE - {11'h000, service_vector, 1'b0})
    else $error("maskable vector address wrong");

  prio_reset_a: assert property ($rose(reset_n)
      |-> s_q.prio == {4{`NPI_PRIO_RESET}})
    else $error("priority registers not at reset value");

  push_level_a: assert property (push_strobe
      |-> $stable(lvl_of(cpu_flags_with_level_bits)))
    else $error("level changed before flags were stacked");

  pair_keep_a: assert property (reg_wr && reg_addr == `NPI_OFF_PRIO1 &&
      reg_wdata[7:6] == `NPI_LVL0 |=> s_q.prio[1][7:6] == $past(s_q.prio[1][7:6]))
    else $error("level 0 written into upper pair");

endmodule

// >>> dv/npi_src_model.sv
// Request sources and instruction boundary model facing the controller
`timescale 1ns/1ps
////////////////////////////////////////
module npi_src_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Bench control
  input wire logic run,
  input wire logic [13:0] set_req,
  // Controller side
  input wire logic service_ack,
  input wire logic [3:0] service_vector,
  output logic [13:0] irq_req,
  output logic cpu_boundary
);
  logic [13:0] ack_clr;

  // Sources hold a request until acknowledged, like latched edge sources
  assign ack_clr = service_ack ? (14'h0001 << service_vector) : 14'h0000;

  // Boundary every cycle while running; busy-time boundaries are ignored
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      irq_req <= 14'h0000;
      cpu_boundary <= 1'b0;
    end else begin
      irq_req <= (irq_req | set_req) & ~ack_clr;
      cpu_boundary <= run;
    end
  end
endmodule

// >>> dv/nested_priority_interrupt_ctrl_bench.sv
// Self-checking bench for the nested priority interrupt controller
`timescale 1ns/1ps
////////////////////////////////////////
module nested_priority_interrupt_ctrl_bench;
  logic mclk, reset_n, reg_wr, reg_rd, run, halt_mode, active_halt_mode;
  logic cpu_boundary, push_strobe, vector_load, service_ack, entry_busy;
  logic jm, jnm, wake_req, busy;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, restore_data, flags;
  logic [5:0] ev;
  logic [3:0] service_vector;
  logic [13:0] set_req, irq_req;
  logic [1:0] push_sel;
  logic [15:0] vector_addr;
  int err_total, compares;

  ////////////////////////////////////////
  npi_ctrl npi_ctrl_i (
    .mclk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq_req,
    .cpu_boundary, .enable_interrupts_instr(ev[0]), .disable_interrupts_instr(ev[1]),
    .halt_instr(ev[2]), .wait_for_request_instr(ev[3]), .trap_instr(ev[4]),
    .flags_restore(ev[5]), .flags_restore_data(restore_data),
    .arith_flags_wr(1'b0), .arith_flags_data(8'h00), .halt_mode, .active_halt_mode,
    .push_strobe, .push_sel, .vector_load, .vector_addr, .service_ack, .service_vector,
    .entry_busy(busy), .cpu_flags_with_level_bits(flags), .jump_if_masked(jm),
    .jump_if_unmasked(jnm), .wake_req
  );
  npi_src_model npi_src_model_i (
    .mclk, .reset_n, .run, .set_req, .service_ack, .service_vector, .irq_req, .cpu_boundary
  );

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  ////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("Counts: %0d compares, %0d mismatches", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  task automatic ev_pulse(input logic [5:0] v);
    @(posedge mclk);
    ev <= v;
    @(posedge mclk);
    ev <= 6'h00;
  endtask

  task automatic req(input logic [13:0] v);
    @(posedge mclk);
    set_req <= v;
    @(posedge mclk);
    set_req <= 14'h0000;
    #1;
  endtask

  task automatic quiet();
    logic seen;
    seen = 1'b0;
    repeat (8) begin
      @(posedge mclk);
      #1;
      seen |= vector_load;
    end
    chk(seen, 1'b0);
  endtask

  // Entry: four pushes in order, then the vector load with the new level
  task automatic wait_load(input logic [15:0] a, input logic [1:0] lv, input logic ak);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    for (int t = 0; t < 20 && !done; t++) begin
      #1;
      if (push_strobe === 1'b1) begin
        chk(push_sel, n[1:0]);
        chk(busy, 1'b1);
        n++;
      end
      done = (vector_load === 1'b1);
      if (!done) begin
        @(posedge mclk);
      end
    end
    if (!done) begin
      err_total++;
      complete_run();
    end else begin
      chk(n[15:0], 16'h0004);
      chk(vector_addr, a);
      chk({flags[5], flags[3]}, lv);
      chk(service_ack, ak);
      chk(busy, 1'b0);
    end
  endtask

  ////////////////////////////////////////
  initial begin
    {reset_n, reg_wr, reg_rd, run, halt_mode, active_halt_mode} = 6'h00;
    {reg_addr, reg_wdata, restore_data} = 24'h000000;
    ev = 6'h00;
    set_req = 14'h0000;
    err_total = 0;
    compares = 0;
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk(flags, 8'hea);
    chk({jm, jnm}, 2'b10);
    for (int i = 0; i < 4; i++) begin
      rdc(8'h24 + 8'(i), 8'hff);
    end
    rdc(8'h20, 8'hea);
    rdc(8'h30, 8'h00);
    wr(8'h27, 8'h00);
    rdc(8'h27, 8'hf0);
    wr(8'h24, 8'hcf);
    wr(8'h24, 8'h64);
    rdc(8'h24, 8'h44);
    // Vector 3 above vector 2 in software level, below it in hardware order
    wr(8'h24, 8'h14);
    rdc(8'h24, 8'h14);
    run <= 1'b1;
    req(14'h000c);
    quiet();
    ev_pulse(6'h01);
    wait_load(16'hfff4, 2'b00, 1'b1);
    chk(service_vector, 4'h3);
    quiet();
    chk({jm, jnm}, 2'b01);
    restore_data <= 8'he2;
    ev_pulse(6'h20);
    wait_load(16'hfff6, 2'b01, 1'b1);
    // Enable, disable, halt, wait in turn
    for (int k = 0; k < 4; k++) begin
      ev_pulse(6'h01 << k);
      @(posedge mclk);
      #1;
      chk({flags[5], flags[3], jm}, (k == 1) ? 3'b111 : 3'b100);
    end
    ev_pulse(6'h02);
    ev_pulse(6'h10);
    wait_load(16'hfffc, 2'b11, 1'b0);
    wr(8'h25, 8'h8b);
    rdc(8'h25, 8'hcf);
    // Vector 2 raised to level 2 while pending inside its own service
    ev_pulse(6'h01);
    req(14'h0004);
    wait_load(16'hfff6, 2'b01, 1'b1);
    req(14'h0004);
    wr(8'h24, 8'h04);
    wait_load(16'hfff6, 2'b00, 1'b1);
    ev_pulse(6'h02);
    @(posedge mclk);
    halt_mode <= 1'b1;
    req(14'h0100);
    chk(wake_req, 1'b0);
    req(14'h0080);
    chk(wake_req, 1'b1);
    @(posedge mclk);
    halt_mode <= 1'b0;
    active_halt_mode <= 1'b1;
    @(posedge mclk);
    #1;
    chk(wake_req, 1'b0);
    req(14'h0002);
    chk(wake_req, 1'b1);
    complete_run();
  end
endmodule
